// *** afpd_datapath.sv ***
// Purpose: eight-channel fixed-point mix datapath with APB registers
// Assumes: one frame of ten samples per inValid pulse, well spaced
// Notes: frames arriving while busy are dropped; see inReady
`timescale 1ns/1ns
module afpd_datapath
    import afpd_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // audio stream
    input wire logic inValid,
    input wire afpd_in_t inData,
    output logic inReady,
    output logic outValid,
    output afpd_out_t outData,
    // modulation select
    output afpd_mod_t modSel
);
    afpd_state_t state_r;
    logic [7:0] modCtl_r;
    logic [3:0][7:0] muxSel_r;
    logic [3:0] csel_r;
    logic native_r;
    logic [15:0] frameCnt_r;
    logic [COEF_W-1:0] coefRam [COEF_DEPTH];
    logic [DATA_W-1:0] offRam [NUM_CH];
    logic [DATA_W-1:0] xWord [NUM_IN];
    logic [DATA_W-1:0] procRam [NUM_CH];
    logic [PROD_W-1:0] acc_r;
    logic [2:0] chan_r;
    logic [3:0] term_r;
    logic outValid_r;
    afpd_out_t outData_r;

    logic [7:0] idx;
    logic apbWr;
    logic apbAcc;
    logic mapped;
    logic [6:0] coefIdx;
    logic [DATA_W-1:0] macA;
    logic [COEF_W-1:0] macB;
    logic signed [PROD_W-1:0] prod;
    logic [PROD_W-1:0] accSum;
    logic [DATA_W-1:0] truncWord;
    logic [DATA_W:0] offSum;
    logic [DATA_W-1:0] satWord;
    logic bypass;
    logic [2:0] outSrc;
    logic lastTerm;
    logic [6:0] busCoefIdx;
    logic [6:0] outCoefIdx;

    assign idx = paddr[9:2];
    assign apbAcc = psel && penable;
    assign apbWr = apbAcc && pwrite;
    assign pready = 1'b1;
    assign inReady = (state_r == AFPD_IDLE);
    assign outValid = outValid_r;
    assign outData = outData_r;
    assign modSel.ternary = modCtl_r[TERNARY_BIT];

    // nibble bit 3 of each mux register picks BD for one output
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_bd
            assign modSel.bdSel[g] = muxSel_r[g/2][(g%2)*4+3];
        end
    endgenerate

    always_comb begin
        mapped = 1'b1;
        busCoefIdx = 7'(idx - IDX_INMIX) * 7'd10 + 7'(csel_r);
        outCoefIdx = 7'(OUTMIX_BASE) + 7'(idx - IDX_OUTMIX) * 7'd3
            + 7'(csel_r);
        if (idx >= IDX_INMIX && idx < IDX_INMIX + 8'd8) begin
            mapped = (csel_r < 4'd10);
        end else if (idx >= IDX_OUTMIX && idx < IDX_OUTMIX + 8'd8) begin
            mapped = (csel_r < 4'd3);
        end else if (idx >= IDX_MUXSEL && idx < IDX_MUXSEL + 8'd4) begin
            mapped = 1'b1;
        end else if (idx >= IDX_OFFSET && idx < IDX_OFFSET + 8'd8) begin
            mapped = 1'b1;
        end else begin
            mapped = (idx == IDX_MODCTL) || (idx == IDX_CSEL)
                || (idx == IDX_CTRL) || (idx == IDX_STATUS);
        end
    end

    assign pslverr = apbAcc && !mapped;

    always_comb begin
        prdata = 32'h00000000;
        if (!mapped) begin
            prdata = 32'h00000000;
        end else if (idx == IDX_MODCTL) begin
            prdata = {24'h000000, modCtl_r};
        end else if (idx >= IDX_MUXSEL && idx < IDX_MUXSEL + 8'd4) begin
            prdata = {24'h000000, muxSel_r[idx[1:0]]};
        end else if (idx >= IDX_INMIX && idx < IDX_INMIX + 8'd8) begin
            prdata = {4'h0, coefRam[busCoefIdx]};
        end else if (idx >= IDX_OUTMIX && idx < IDX_OUTMIX + 8'd8) begin
            prdata = {4'h0, coefRam[outCoefIdx]};
        end else if (idx >= IDX_OFFSET && idx < IDX_OFFSET + 8'd8) begin
            prdata = offRam[idx[2:0]];
        end else if (idx == IDX_CSEL) begin
            prdata = {28'h0000000, csel_r};
        end else if (idx == IDX_CTRL) begin
            prdata = {31'h00000000, native_r};
        end else begin
            prdata = {frameCnt_r, 13'h0000, state_r != AFPD_IDLE,
                native_r, modCtl_r[TERNARY_BIT]};
        end
    end

    // control registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            modCtl_r <= MODCTL_RST;
            muxSel_r <= '0;
            csel_r <= 4'h0;
            native_r <= 1'b0;
        end else if (apbWr && mapped) begin
            if (idx == IDX_MODCTL) begin
                modCtl_r <= pwdata[7:0];
            end
            if (idx >= IDX_MUXSEL && idx < IDX_MUXSEL + 8'd4) begin
                muxSel_r[idx[1:0]] <= pwdata[7:0];
            end
            if (idx == IDX_CSEL) begin
                csel_r <= pwdata[3:0];
            end
            if (idx == IDX_CTRL) begin
                native_r <= pwdata[NATIVE_BIT];
            end
        end
    end

    // coefficient and offset RAMs: the two stores the bus can write
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < COEF_DEPTH; i++) begin
                coefRam[i] <= '0;
            end
            // identity crossbar and unity first output source
            for (int c = 0; c < NUM_CH; c++) begin
                coefRam[c*NUM_IN+c] <= COEF_UNITY;
                coefRam[OUTMIX_BASE+c*3] <= COEF_UNITY;
            end
            for (int c = 0; c < NUM_CH; c++) begin
                offRam[c] <= '0;
            end
        end else if (apbWr && mapped) begin
            if (idx >= IDX_INMIX && idx < IDX_INMIX + 8'd8) begin
                coefRam[busCoefIdx] <= pwdata[COEF_W-1:0];
            end
            if (idx >= IDX_OUTMIX && idx < IDX_OUTMIX + 8'd8) begin
                coefRam[outCoefIdx] <= pwdata[COEF_W-1:0];
            end
            if (idx >= IDX_OFFSET && idx < IDX_OFFSET + 8'd8) begin
                offRam[idx[2:0]] <= pwdata;
            end
        end
    end

    // operand selection for the single multiplier
    always_comb begin
        bypass = native_r && (chan_r >= 3'd2) && (chan_r <= 3'd5);
        case (term_r)
            4'd0: outSrc = chan_r;
            4'd1: outSrc = (chan_r < 3'd6) ? (chan_r ^ 3'd1)
                : ((chan_r == 3'd6) ? 3'd0 : 3'd1);
            default: outSrc = chan_r ^ 3'd1;
        endcase
        lastTerm = (chan_r >= 3'd6) ? (term_r == 4'd2)
            : (term_r == 4'd1);
        if (state_r == AFPD_OMIX) begin
            macA = procRam[outSrc];
            coefIdx = 7'(OUTMIX_BASE) + 7'(chan_r) * 7'd3 + 7'(term_r);
        end else begin
            macA = xWord[term_r];
            coefIdx = 7'(chan_r) * 7'd10 + 7'(term_r);
        end
        macB = coefRam[coefIdx];
    end

    // signed 9.23 by 5.23 gives 14.46; keep bits aligned to 9.23
    assign prod = $signed(macA) * $signed(macB);
    assign accSum = acc_r + PROD_W'(prod);
    assign truncWord = acc_r[DATA_W+FRAC_W-1:FRAC_W];
    assign offSum = {truncWord[DATA_W-1], truncWord}
        + {offRam[chan_r][DATA_W-1], offRam[chan_r]};

    always_comb begin
        if (offSum[DATA_W] != offSum[DATA_W-1]) begin
            satWord = offSum[DATA_W] ? SAT_MIN : SAT_MAX;
        end else begin
            satWord = offSum[DATA_W-1:0];
        end
    end

    // sequencer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= AFPD_IDLE;
            chan_r <= 3'd0;
            term_r <= 4'd0;
            acc_r <= '0;
        end else begin
            case (state_r)
                AFPD_IDLE: begin
                    if (inValid) begin
                        state_r <= AFPD_MIX;
                    end
                    chan_r <= 3'd0;
                    term_r <= 4'd0;
                    acc_r <= '0;
                end
                AFPD_MIX: begin
                    acc_r <= accSum;
                    if (term_r == 4'(NUM_IN-1)) begin
                        state_r <= AFPD_STORE;
                        term_r <= 4'd0;
                    end else begin
                        term_r <= term_r + 4'd1;
                    end
                end
                AFPD_STORE: begin
                    acc_r <= '0;
                    chan_r <= chan_r + 3'd1;
                    if (chan_r == 3'd7) begin
                        state_r <= AFPD_OMIX;
                    end else begin
                        state_r <= AFPD_MIX;
                    end
                end
                AFPD_OMIX: begin
                    acc_r <= accSum;
                    if (lastTerm) begin
                        state_r <= AFPD_OSTORE;
                        term_r <= 4'd0;
                    end else begin
                        term_r <= term_r + 4'd1;
                    end
                end
                AFPD_OSTORE: begin
                    acc_r <= '0;
                    chan_r <= chan_r + 3'd1;
                    state_r <= (chan_r == 3'd7) ? AFPD_IDLE : AFPD_OMIX;
                end
                default: begin
                    state_r <= AFPD_IDLE;
                end
            endcase
        end
    end

    // data RAM: input frame and intermediate channel words
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_IN; i++) begin
                xWord[i] <= '0;
            end
            for (int c = 0; c < NUM_CH; c++) begin
                procRam[c] <= '0;
            end
        end else begin
            if (state_r == AFPD_IDLE && inValid) begin
                for (int i = 0; i < NUM_IN; i++) begin
                    // sign fills guard bits, low bits are zero
                    xWord[i] <= {{GUARD_W{inData.sample[i][SAMPLE_W-1]}},
                        inData.sample[i],
                        {(DATA_W-GUARD_W-SAMPLE_W){1'b0}}};
                end
            end
            if (state_r == AFPD_STORE) begin
                procRam[chan_r] <= bypass ? xWord[chan_r] : satWord;
            end
        end
    end

    // output words and frame counter
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            outData_r <= '0;
            outValid_r <= 1'b0;
            frameCnt_r <= 16'h0000;
        end else begin
            outValid_r <= (state_r == AFPD_OSTORE) && (chan_r == 3'd7);
            if (state_r == AFPD_OSTORE) begin
                outData_r.word[chan_r] <= bypass ? procRam[chan_r]
                    : truncWord;
                if (chan_r == 3'd7) begin
                    frameCnt_r <= frameCnt_r + 16'h0001;
                end
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    ternary_follow_a: assert property (
        apbWr && idx == IDX_MODCTL |=> modSel.ternary == $past(pwdata[5]))
        else $error("ternary select did not follow control write");
    bd_select_a: assert property (
        apbWr && idx == IDX_MUXSEL |=> modSel.bdSel[0] == $past(pwdata[3]))
        else $error("bd select did not follow mux write");
    offset_sat_a: assert property (
        state_r == AFPD_STORE && !bypass && !offSum[DATA_W]
        && offSum[DATA_W-1] |=> procRam[$past(chan_r)] == SAT_MAX)
        else $error("positive overflow not clamped");
    native_bypass_a: assert property (
        state_r == AFPD_STORE && bypass
        |=> procRam[$past(chan_r)] == xWord[$past(chan_r)])
        else $error("native bypass channel was processed");
    frame_done_a: assert property (
        state_r == AFPD_IDLE && inValid |-> ##[100:130] outValid)
        else $error("frame not finished in time");
    acc_clear_a: assert property (
        state_r == AFPD_STORE || state_r == AFPD_OSTORE |=> acc_r == '0)
        else $error("accumulator not cleared between outputs");
    coef_top_a: assert property (
        apbAcc && !pwrite && idx >= IDX_INMIX && idx < IDX_INMIX + 8'd8
        |-> prdata[31:28] == 4'h0)
        else $error("coefficient upper bits not zero");
    unmapped_err_a: assert property (
        apbAcc && idx == 8'h51 |-> pslverr)
        else $error("unmapped address accepted");
    mix_terms_a: assert property (
        state_r == AFPD_OMIX && chan_r < 3'd6 |-> term_r < 4'd2)
        else $error("output mixer used too many sources");
    offset_neg_a: assert property (
        state_r == AFPD_STORE && !bypass && offSum[DATA_W]
        && !offSum[DATA_W-1] |=> procRam[$past(chan_r)] == SAT_MIN)
        else $error("negative overflow not clamped");
    out_pulse_a: assert property (
        outValid |=> !outValid)
        else $error("frame done strobe longer than one cycle");
    csel_refuse_a: assert property (
        apbAcc && idx >= IDX_INMIX && idx < IDX_INMIX + 8'd8
        && csel_r >= 4'd10 |-> pslverr)
        else $error("crossbar access past last input accepted");
endmodule // afpd_datapath

// *** afpd_pkg.sv ***
// Purpose: constants and carriers of the audio fixed-point datapath
// Assumes: APB register access, one processing clock
// Notes: register offsets are word indices; byte address is four times
package afpd_pkg;
    localparam int NUM_IN = 10;
    localparam int NUM_CH = 8;
    localparam int SAMPLE_W = 24;
    localparam int DATA_W = 32;
    localparam int COEF_W = 28;
    localparam int PROD_W = 60;
    localparam int GUARD_W = 4;
    localparam int FRAC_W = 23;
    // register indices
    localparam logic [7:0] IDX_MODCTL = 8'h25;
    localparam logic [7:0] IDX_MUXSEL = 8'h30;
    localparam logic [7:0] IDX_INMIX = 8'h41;
    localparam logic [7:0] IDX_OUTMIX = 8'hE0;
    localparam logic [7:0] IDX_OFFSET = 8'hE8;
    localparam logic [7:0] IDX_CSEL = 8'hF0;
    localparam logic [7:0] IDX_CTRL = 8'hF1;
    localparam logic [7:0] IDX_STATUS = 8'hF2;
    localparam int TERNARY_BIT = 5;
    localparam int NATIVE_BIT = 0;
    // coefficient RAM layout, clamp limits and reset values
    localparam int OUTMIX_BASE = 80;
    localparam int COEF_DEPTH = 104;
    localparam logic [COEF_W-1:0] COEF_UNITY = 28'h0800000;
    localparam logic [DATA_W-1:0] SAT_MAX = 32'h7FFFFFFF;
    localparam logic [DATA_W-1:0] SAT_MIN = 32'h80000000;
    localparam logic [7:0] MODCTL_RST = 8'h00;

    typedef enum logic [2:0] {
        AFPD_IDLE = 3'b000,
        AFPD_MIX = 3'b001,
        AFPD_STORE = 3'b011,
        AFPD_OMIX = 3'b010,
        AFPD_OSTORE = 3'b110
    } afpd_state_t;

    typedef struct packed {
        logic [NUM_IN-1:0][SAMPLE_W-1:0] sample;
    } afpd_in_t;

    typedef struct packed {
        logic [NUM_CH-1:0][DATA_W-1:0] word;
    } afpd_out_t;

    typedef struct packed {
        logic ternary;
        logic [NUM_CH-1:0] bdSel;
    } afpd_mod_t;
endpackage

// *** afpd_src_model.sv ***
// Purpose: audio source that hands one ten-sample frame to the datapath
// Assumes: a go pulse from the bench starts one frame
// Notes: between frames the data lines toggle each cycle, so stale values match again every second cycle
`timescale 1ns/1ns
module afpd_src_model
    import afpd_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // bench side
    input wire logic go,
    input wire afpd_in_t smp,
    // datapath side
    output logic inValid,
    output afpd_in_t inData
);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            inValid <= 1'b0;
            inData <= '0;
        end else if (go) begin
            inValid <= 1'b1;
            inData <= smp;
        end else begin
            inValid <= 1'b0;
            // invert while idle: a frame sampled one cycle too late shows as garbage
            inData <= ~inData;
        end
    end
endmodule // afpd_src_model

// *** tb_afpd_datapath.sv ***
// Purpose: self-checking bench of the fixed-point mix datapath
// Assumes: apb with zero wait states, frames kept only when sent while idle
// Notes: expected words come from a bit-exact model of mix and clamp
`timescale 1ns/1ns
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin \
 errCount++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); \
 end end
module tb_afpd_datapath
    import afpd_pkg::*;
;
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic pready, pslverr, inValid, inReady, outValid, go = 0, e;
    afpd_in_t inData, smp = '0;
    afpd_out_t outData, ex;
    afpd_mod_t modSel;
    int errCount = 0, samplesChecked = 0, seed = 32'hb33a;
    logic [31:0] mx;
    afpd_out_t expQ[$];
    logic signed [27:0] xw[8][10], og[8][3];
    logic signed [31:0] off[8];
    bit nat = 0;
    afpd_datapath dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .inValid(inValid), .inData(inData), .inReady(inReady),
        .outValid(outValid), .outData(outData), .modSel(modSel));
    afpd_src_model src (.core_clk(core_clk), .rstn(rstn), .go(go),
        .smp(smp), .inValid(inValid), .inData(inData));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic finalReport();
        if (errCount == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input bit wr, input logic [7:0] idx,
        input logic [31:0] wd, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            errCount++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // upper nibble is junk on purpose: it must be ignored
    task automatic wxw(int c, int i, logic [27:0] v);
        apb(1, IDX_CSEL, i, r, e);
        apb(1, IDX_INMIX + c, {4'hA, v}, r, e);
        xw[c][i] = v;
    endtask
    task automatic wog(int c, int s, logic [27:0] v);
        apb(1, IDX_CSEL, s, r, e);
        apb(1, IDX_OUTMIX + c, {4'h5, v}, r, e);
        og[c][s] = v;
    endtask
    function automatic afpd_out_t expv(afpd_in_t d);
        logic signed [31:0] w[10], ch[8];
        logic signed [59:0] acc;
        logic [32:0] s;
        int src[3];
        afpd_out_t o;
        for (int i = 0; i < 10; i++) begin
            w[i] = {{4{d.sample[i][23]}}, d.sample[i], 4'h0};
        end
        for (int c = 0; c < 8; c++) begin
            acc = '0;
            for (int i = 0; i < 10; i++) begin
                acc = acc + w[i] * xw[c][i];
            end
            s = {acc[54], acc[54:23]} + {off[c][31], off[c]};
            ch[c] = (s[32] != s[31]) ? (s[32] ? SAT_MIN : SAT_MAX) : s[31:0];
            if (nat && c >= 2 && c <= 5) begin
                ch[c] = w[c];
            end
        end
        for (int c = 0; c < 8; c++) begin
            src = '{c, (c < 6) ? (c ^ 1) : (c == 6 ? 0 : 1), (c == 6) ? 7 : 6};
            acc = '0;
            for (int k = 0; k < ((c < 6) ? 2 : 3); k++) begin
                acc = acc + ch[src[k]] * og[c][k];
            end
            o.word[c] = acc[54:23];
            if (nat && c >= 2 && c <= 5) begin
                o.word[c] = w[c];
            end
        end
        return o;
    endfunction
    task automatic frame(bit keep, bit edge_vals);
        afpd_in_t d;
        for (int i = 0; i < 10; i++) begin
            d.sample[i] = $random(seed);
        end
        if (edge_vals) begin
            d.sample[0] = 24'h800000;
            d.sample[1] = 24'h7FFFFF;
        end
        smp <= d;
        go <= 1;
        @(posedge core_clk);
        go <= 0;
        if (keep) begin
            expQ.push_back(expv(d));
        end
    endtask
    task automatic idle();
        int n;
        n = 0;
        repeat (4) @(posedge core_clk);
        while (inReady !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 500) begin
            errCount++;
        end
    endtask
    always @(posedge core_clk) begin
        if (outValid === 1'b1) begin
            if (expQ.size() == 0) begin
                errCount++;
                $display("BAD t=%0t got=%h exp=%h", $time, outData, 0);
            end else begin
                ex = expQ.pop_front();
                `CHK(outData, ex)
            end
        end
    end
    initial begin
        #80000;
        errCount++;
        finalReport();
    end
    initial begin
        for (int c = 0; c < 8; c++) begin
            off[c] = '0;
            for (int i = 0; i < 10; i++) begin
                xw[c][i] = (i == c) ? COEF_UNITY : '0;
            end
            og[c] = '{COEF_UNITY, 28'h0, 28'h0};
        end
        repeat (12) @(posedge core_clk);
        rstn <= 1;
        `CHK(modSel, 9'h000)
        apb(0, IDX_MODCTL, 0, r, e);
        `CHK(r, 32'h00000000)
        apb(0, IDX_INMIX, 0, r, e);
        `CHK(r, {4'h0, COEF_UNITY})
        apb(0, 8'h10, 0, r, e);
        `CHK({e, r}, 33'h100000000)
        apb(1, IDX_CSEL, 10, r, e);
        apb(1, IDX_INMIX, 32'h00123456, r, e);
        `CHK(e, 1'b1)
        // identity weights make both clamps certain on channels 0 and 1
        off[0] = SAT_MIN;
        off[1] = SAT_MAX;
        apb(1, IDX_OFFSET, SAT_MIN, r, e);
        apb(1, IDX_OFFSET + 1, SAT_MAX, r, e);
        frame(1, 1);
        idle();
        for (int k = 0; k < 8; k++) begin
            wxw(k, $unsigned($random(seed)) % 10, $random(seed));
            wog(k, (k < 6) ? 1 : 2, $random(seed));
        end
        wxw(3, 9, 28'hF800000);
        apb(0, IDX_INMIX + 3, 0, r, e);
        `CHK(r, 32'h0F800000)
        frame(1, 1);
        repeat (6) @(posedge core_clk);
        frame(0, 0);
        idle();
        frame(1, 0);
        idle();
        apb(1, IDX_MODCTL, 32'h00000020, r, e);
        @(posedge core_clk);
        `CHK(modSel.ternary, 1'b1)
        for (int k = 0; k < 4; k++) begin
            mx = $random(seed);
            apb(1, IDX_MUXSEL + k, mx, r, e);
            @(posedge core_clk);
            r[1:0] = {modSel.bdSel[2*k+1], modSel.bdSel[2*k]};
            `CHK(r[1:0], {mx[7], mx[3]})
        end
        apb(1, IDX_CTRL, 1, r, e);
        nat = 1;
        apb(0, IDX_STATUS, 0, r, e);
        `CHK(r[1:0], 2'b11)
        frame(1, 0);
        idle();
        repeat (300) begin
            if (expQ.size() != 0) begin
                @(posedge core_clk);
            end
        end
        `CHK(expQ.size(), 0)
        finalReport();
    end
endmodule // tb_afpd_datapath
